// ---- hw/ppr_map.svh ----
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH
// mode register numbers on the ba/bg decode
`define PPR_MR0          3'h0
`define PPR_MR4          3'h4
// repair enable bits in mode register 4
`define PPR_SOFT_BIT     5
`define PPR_HARD_BIT     13
// guard key address fields
`define PPR_KEY_LSB      7
`define PPR_KEY_MSB      11
`define PPR_KEY_ONES     7'h7f
`define PPR_KEY1         5'h19
`define PPR_KEY2         5'h0f
`define PPR_KEY3         5'h17
`define PPR_KEY4         5'h07
// burst length in beats checked on dq
`define PPR_BURST_BEATS  4'h8
// beats of all-high data that cancel the repair (two clocks)
`define PPR_HIGH_BEATS   4'h4
`endif

// ---- hw/ppr_pkg.sv ----
package ppr_pkg;
    typedef enum logic [2:0] {
        CMD_DES,
        CMD_MRS,
        CMD_ACT,
        CMD_WR,
        CMD_PRE,
        CMD_REF,
        CMD_OTHER
    } ppr_cmd_e;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_KEY1,
        ST_KEY2,
        ST_KEY3,
        ST_KEY4,
        ST_ARMED,
        ST_ROW,
        ST_PROG,
        ST_EXIT
    } ppr_state_e;
endpackage

// ---- hw/ppr_repair.sv ----
`timescale 1ns/1ps
`include "ppr_map.svh"
module ppr_repair
    import ppr_pkg::*;
#(
    parameter int ROW_W  = 18,   // row address width
    parameter int BANKS  = 16,   // bank groups times banks
    parameter int DQ_W   = 8,    // dq lanes of this device
    parameter int WL     = 9     // write latency in clocks
) (
    input  wire logic                     mclk_i,         // command clock
    input  wire logic                     resetn_i,       // async reset, active low
    input  wire logic                     ce_i,           // clock enable
    input  wire logic                     cmd_valid_i,    // command present this cycle
    input  wire ppr_cmd_e                 cmd_i,          // decoded command
    input  wire logic [2:0]               mr_sel_i,       // mode register number
    input  wire logic [3:0]               bank_i,         // bank group and bank
    input  wire logic [ROW_W-1:0]         addr_i,         // address bus
    input  wire logic [2*DQ_W-1:0]        dq_pair_i,      // two beats of dq per clock
    input  wire logic [BANKS-1:0]         spare_ok_i,     // bank has a spare row
    output logic                          soft_mode_o,    // soft repair mode on
    output logic                          hard_mode_o,    // hard repair mode on
    output logic                          dq_high_o,      // drive every dq high
    output logic                          normal_cmd_o,   // act/wr pass as ordinary
    output logic                          repair_done_o,  // pulse: row programmed
    output logic [BANKS-1:0]              rep_valid_o,    // bank holds a soft repair
    output logic [BANKS*ROW_W-1:0]        rep_row_o       // repaired row per bank
);
    localparam int CW = $clog2(WL + 16);

    ppr_state_e             state_ff;
    logic                   soft_ff, hard_ff;
    logic [3:0]             tbank_ff;
    logic [ROW_W-1:0]       trow_ff;
    logic [CW-1:0]          wcnt_ff;
    logic                   burst_ff;
    logic [3:0]             beat_ff;
    logic                   any_high_ff;
    logic                   lead_high_ff;
    logic                   ok_ff;
    logic [BANKS-1:0]       rvalid_ff;
    logic [ROW_W-1:0]       rrow_ff [BANKS];
    logic                   done_ff;
    logic                   key_ok;
    logic [4:0]             key_want;
    logic                   mrs4;
    logic                   all_low, all_high;

    // mode register 4 write and guard key decode
    assign mrs4     = cmd_valid_i && cmd_i == CMD_MRS && mr_sel_i == `PPR_MR4;
    always_comb begin
        unique case (state_ff)
            ST_KEY1: key_want = `PPR_KEY1;
            ST_KEY2: key_want = `PPR_KEY2;
            ST_KEY3: key_want = `PPR_KEY3;
            default: key_want = `PPR_KEY4;
        endcase
    end
    assign key_ok   = cmd_valid_i && cmd_i == CMD_MRS && mr_sel_i == `PPR_MR0 && bank_i == 4'h0
                      && addr_i[6:0] == `PPR_KEY_ONES
                      && addr_i[`PPR_KEY_MSB:`PPR_KEY_LSB] == key_want;
    assign all_low  = ~|dq_pair_i;
    assign all_high = &dq_pair_i;

    // mode enable bits follow mode register 4 writes
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_ff <= 1'b0;
            hard_ff <= 1'b0;
        end else if (ce_i && mrs4) begin
            soft_ff <= addr_i[`PPR_SOFT_BIT];
            hard_ff <= addr_i[`PPR_HARD_BIT];
        end
    end

    // repair sequence state; any stray command drops back to idle
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
            tbank_ff <= 4'h0;
            trow_ff  <= '0;
        end else if (ce_i) begin
            if (mrs4 && !addr_i[`PPR_SOFT_BIT] && !addr_i[`PPR_HARD_BIT]) begin
                state_ff <= ST_IDLE;
            end else if (mrs4) begin
                state_ff <= ST_KEY1;
            end else if (cmd_valid_i && cmd_i != CMD_DES) begin
                unique case (state_ff)
                    ST_KEY1, ST_KEY2, ST_KEY3, ST_KEY4: begin
                        if (!key_ok)
                            state_ff <= ST_IDLE;
                        else if (state_ff == ST_KEY4)
                            state_ff <= ST_ARMED;
                        else
                            state_ff <= ppr_state_e'(state_ff + 4'h1);
                    end
                    ST_ARMED: begin
                        if (cmd_i == CMD_ACT) begin
                            state_ff <= ST_ROW;
                            tbank_ff <= bank_i;
                            trow_ff  <= addr_i;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_ROW: begin
                        if (cmd_i == CMD_WR && bank_i == tbank_ff)
                            state_ff <= ST_PROG;
                        else
                            state_ff <= ST_IDLE;
                    end
                    ST_PROG: begin
                        if (cmd_i == CMD_PRE)
                            state_ff <= ST_EXIT;
                        else
                            state_ff <= ST_IDLE;
                    end
                    ST_EXIT: state_ff <= ST_IDLE;
                    ST_IDLE: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // write latency wait, then eight-beat dq check
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wcnt_ff      <= '0;
            burst_ff     <= 1'b0;
            beat_ff      <= 4'h0;
            any_high_ff  <= 1'b0;
            lead_high_ff <= 1'b0;
            ok_ff        <= 1'b0;
        end else if (ce_i) begin
            if (state_ff == ST_ROW && cmd_valid_i && cmd_i == CMD_WR && bank_i == tbank_ff) begin
                wcnt_ff      <= CW'(WL);
                burst_ff     <= 1'b0;
                beat_ff      <= 4'h0;
                any_high_ff  <= 1'b0;
                lead_high_ff <= 1'b1;
                ok_ff        <= 1'b0;
            end else if (wcnt_ff != '0) begin
                wcnt_ff  <= wcnt_ff - CW'(1);
                burst_ff <= (wcnt_ff == CW'(1));
            end else if (burst_ff) begin
                any_high_ff <= any_high_ff | ~all_low;
                if (beat_ff < `PPR_HIGH_BEATS)
                    lead_high_ff <= lead_high_ff & all_high;
                beat_ff <= beat_ff + 4'h2;
                if (beat_ff + 4'h2 == `PPR_BURST_BEATS) begin
                    burst_ff <= 1'b0;
                    ok_ff    <= !(any_high_ff | ~all_low);
                end
            end
        end
    end

    // per-bank repaired row store; precharge completes the repair
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_ff <= '0;
            done_ff   <= 1'b0;
            for (int i = 0; i < BANKS; i++)
                rrow_ff[i] <= '0;
        end else if (ce_i) begin
            done_ff <= 1'b0;
            if (state_ff == ST_PROG && cmd_valid_i && cmd_i == CMD_PRE && soft_ff
                && ok_ff && !lead_high_ff && spare_ok_i[tbank_ff]) begin
                rvalid_ff[tbank_ff] <= 1'b1;
                rrow_ff[tbank_ff]   <= trow_ff;
                done_ff             <= 1'b1;
            end
        end
    end

    // outputs; other rows of the bank are untouched by the store
    generate
        for (genvar g = 0; g < BANKS; g++) begin : g_row
            assign rep_row_o[g*ROW_W +: ROW_W] = rrow_ff[g];
        end
    endgenerate
    assign soft_mode_o   = soft_ff;
    assign hard_mode_o   = hard_ff;
    assign dq_high_o     = soft_ff;
    assign normal_cmd_o  = (state_ff == ST_IDLE);
    assign repair_done_o = done_ff;
    assign rep_valid_o   = rvalid_ff;

    // checks
    key_abort_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_KEY2 && cmd_valid_i && cmd_i != CMD_DES && !mrs4 && !key_ok
        |=> state_ff == ST_IDLE) else $error("broken key sequence did not abort");
    key_arm_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_KEY4 && key_ok && !mrs4 |=> state_ff == ST_ARMED)
        else $error("fourth key did not arm");
    row_cap_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_ARMED && cmd_valid_i && cmd_i == CMD_ACT && !mrs4
        |=> state_ff == ST_ROW && trow_ff == $past(addr_i))
        else $error("target row not captured");
    dq_high_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 && addr_i[`PPR_SOFT_BIT] |=> dq_high_o)
        else $error("dq not driven high on soft enable");
    no_arm_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        state_ff == ST_IDLE && !mrs4 |=> state_ff == ST_IDLE)
        else $error("left idle without mode entry");
    repair_ok_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        repair_done_o |-> $past(ok_ff) && !$past(lead_high_ff))
        else $error("repair without all-low burst");
    bank_store_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        repair_done_o |-> rep_valid_o[$past(tbank_ff)] && rrow_ff[$past(tbank_ff)] == $past(trow_ff))
        else $error("repaired row not stored in bank");
    mode_bit_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 |=> hard_mode_o == $past(addr_i[`PPR_HARD_BIT]))
        else $error("hard mode bit mismatch");
    exit_idle_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 && !addr_i[`PPR_SOFT_BIT] && !addr_i[`PPR_HARD_BIT] |=> normal_cmd_o)
        else $error("disable did not return to idle");

    // clock enable low freezes the sequence and the store
    ce_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !ce_i |=> $stable(state_ff) && $stable(soft_ff) && $stable(rvalid_ff))
        else $error("state moved with clock enable low");

    // soft mode output follows bit 5 of each mode register 4 write
    soft_bit_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 |=> soft_mode_o == $past(addr_i[`PPR_SOFT_BIT]))
        else $error("soft mode bit mismatch");

    // first key moves on to the second key step
    key_step_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_KEY1 && key_ok && !mrs4 |=> state_ff == ST_KEY2)
        else $error("first key not accepted");

    // an enabling mode write always restarts the key sequence
    entry_key_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 && (addr_i[`PPR_SOFT_BIT] || addr_i[`PPR_HARD_BIT]) |=> state_ff == ST_KEY1)
        else $error("mode entry did not restart keys");

    // interrupted third key step aborts the entry
    key_break_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_KEY3 && cmd_valid_i && cmd_i != CMD_DES && !mrs4 && !key_ok
        |=> state_ff == ST_IDLE) else $error("interrupted keys did not abort");

    // write to the captured bank enters programming
    row_wr_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_ROW && cmd_valid_i && cmd_i == CMD_WR && bank_i == tbank_ff && !mrs4
        |=> state_ff == ST_PROG) else $error("write to target bank not taken");

    // the write loads the latency counter
    wr_load_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_ROW && cmd_valid_i && cmd_i == CMD_WR && bank_i == tbank_ff
        |=> wcnt_ff == CW'(WL)) else $error("write latency not loaded");

    // the burst window opens at beat zero
    burst_start_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        $rose(burst_ff) |-> beat_ff == 4'h0)
        else $error("burst opened mid-way");

    // the burst window closes after the fourth clock
    beat_end_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && burst_ff && wcnt_ff == '0 && beat_ff == 4'h6 |=> !burst_ff)
        else $error("burst window overran");

    // all-high leading beats block the repair
    lead_block_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_PROG && cmd_valid_i && cmd_i == CMD_PRE && lead_high_ff
        |=> !repair_done_o) else $error("repair despite all-high burst");

    // precharge after programming moves to exit
    exit_state_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && state_ff == ST_PROG && cmd_valid_i && cmd_i == CMD_PRE && !mrs4
        |=> state_ff == ST_EXIT) else $error("precharge did not end programming");

    // done is a single-cycle pulse
    done_pulse_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        repair_done_o && ce_i |=> !repair_done_o)
        else $error("repair done held too long");

    // no repair lands in a bank without a spare
    spare_need_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        repair_done_o |-> $past(spare_ok_i[tbank_ff]))
        else $error("repair stored without spare");

    // only soft mode stores rows
    soft_need_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        repair_done_o |-> $past(soft_ff))
        else $error("repair stored outside soft mode");

    // repaired-bank flags change only with a repair
    valid_change_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        rep_valid_o != $past(rep_valid_o) |-> repair_done_o)
        else $error("repair flags changed without repair");

    // leaving soft mode releases the dq lanes
    dq_off_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ce_i && mrs4 && !addr_i[`PPR_SOFT_BIT] |=> !dq_high_o)
        else $error("dq still driven high after disable");
endmodule

// ---- tb/ppr_ctl_model.sv ----
`timescale 1ns/1ps
`include "ppr_map.svh"
// controller side: one command at a time, then the write burst
module ppr_ctl_model
    import ppr_pkg::*;
#(
    parameter int ROW_W = 18,  // row address width
    parameter int DQ_W  = 8,   // dq lanes
    parameter int WL    = 9    // write latency in clocks
) (
    input  wire logic          mclk_i,       // command clock
    output logic               cmd_valid_o,  // command present
    output ppr_cmd_e           cmd_o,        // decoded command
    output logic [2:0]         mr_sel_o,     // mode register number
    output logic [3:0]         bank_o,       // bank group and bank
    output logic [ROW_W-1:0]   addr_o,       // address bus
    output logic [2*DQ_W-1:0]  dq_pair_o     // two dq beats per clock
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = CMD_DES;
        mr_sel_o = 3'h0;
        bank_o = 4'h0;
        addr_o = '0;
        dq_pair_o = '1;
    end
    // hold a command for one clock; refresh is never issued in repair mode
    task automatic issue(input ppr_cmd_e c, input logic [2:0] mr, input logic [3:0] bk,
                         input logic [ROW_W-1:0] ad);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        mr_sel_o <= mr;
        bank_o <= bk;
        addr_o <= ad;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_o <= CMD_DES;
        addr_o <= ~ad;  // released bus does not keep its value
    endtask
    // enable soft mode, then the four keys; bad 1 swaps keys, bad 2 interrupts them
    task automatic enter(input int bad);
        logic [4:0] k [4];
        k[0] = `PPR_KEY1;
        k[1] = `PPR_KEY2;
        k[2] = `PPR_KEY3;
        k[3] = `PPR_KEY4;
        if (bad == 1) begin
            k[1] = `PPR_KEY3;
            k[2] = `PPR_KEY2;
        end
        issue(CMD_MRS, `PPR_MR4, 4'h0, ROW_W'(1) << `PPR_SOFT_BIT);
        for (int i = 0; i < 4; i++) begin
            if (bad == 2 && i == 2)
                issue(CMD_MRS, 3'h2, 4'h0, '0);
            issue(CMD_MRS, `PPR_MR0, 4'h0, {6'(i * 13), k[i], `PPR_KEY_ONES});
        end
    endtask
    // drive the pattern for the four clocks after write latency
    task automatic burst(input logic [2*DQ_W-1:0] pat);
        for (int i = 1; i <= WL + 4; i++) begin
            @(posedge mclk_i);
            dq_pair_o <= (i >= WL && i < WL + 4) ? pat : ~dq_pair_o;
        end
    endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "ppr_map.svh"
module tb_top;
    import ppr_pkg::*;
    localparam int ROW_W = 18;
    localparam int BANKS = 16;
    localparam int DQ_W  = 8;
    localparam int WL    = 9;
    logic                    mclk_i, resetn_i, ce_i, cmd_valid;
    ppr_cmd_e                cmd;
    logic [2:0]              mr_sel;
    logic [3:0]              bank;
    logic [ROW_W-1:0]        addr;
    logic [2*DQ_W-1:0]       dq_pair;
    logic [BANKS-1:0]        spare_ok, rep_valid, exp_valid;
    logic                    soft_mode, hard_mode, dq_high, normal_cmd, repair_done;
    logic [BANKS*ROW_W-1:0]  rep_row, exp_row;
    int                      bad_count = 0;
    int                      num_checks = 0;
    int                      seed = 32'hc449;

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    ppr_repair #(.ROW_W(ROW_W), .BANKS(BANKS), .DQ_W(DQ_W), .WL(WL)) u_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
        .mr_sel_i(mr_sel), .bank_i(bank), .addr_i(addr), .dq_pair_i(dq_pair), .spare_ok_i(spare_ok),
        .soft_mode_o(soft_mode), .hard_mode_o(hard_mode), .dq_high_o(dq_high),
        .normal_cmd_o(normal_cmd), .repair_done_o(repair_done), .rep_valid_o(rep_valid),
        .rep_row_o(rep_row));
    ppr_ctl_model #(.ROW_W(ROW_W), .DQ_W(DQ_W), .WL(WL)) u_ctl (
        .mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .mr_sel_o(mr_sel),
        .bank_o(bank), .addr_o(addr), .dq_pair_o(dq_pair));

    task automatic chk(input string nm, input logic [BANKS*ROW_W-1:0] e, input logic [BANKS*ROW_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // a repair is stored only for intact keys, an all-low burst and a spare
    function automatic logic fixes(input logic [2*DQ_W-1:0] pat, input int bad, input logic spare);
        return bad == 0 && pat == '0 && spare;
    endfunction

    // one full soft repair pass, from enable to disable
    task automatic seq(input logic [3:0] bk, input logic [ROW_W-1:0] row, input logic [2*DQ_W-1:0] pat,
                       input int bad);
        int   pulses;
        logic fix;
        pulses = 0;
        u_ctl.enter(bad);
        #1;
        fix = fixes(pat, bad, spare_ok[bk]);
        chk("soft_mode", 1, soft_mode);
        chk("dq_high", 1, dq_high);
        u_ctl.issue(CMD_ACT, 3'h0, bk, row);
        #1;
        if (bad != 0 || spare_ok[bk])
            chk("normal_cmd", bad != 0, normal_cmd);
        u_ctl.issue(CMD_WR, 3'h0, bk, ROW_W'($random(seed)));
        u_ctl.burst(pat);
        u_ctl.issue(CMD_PRE, 3'h0, bk, '0);
        for (int i = 0; i < 3; i++) begin
            #1;
            if (repair_done === 1'b1)
                pulses++;
            @(posedge mclk_i);
        end
        chk("repair_done", fix, pulses);
        if (fix) begin
            exp_valid[bk] = 1'b1;
            exp_row[bk*ROW_W +: ROW_W] = row;
        end
        chk("rep_valid", exp_valid, rep_valid);
        chk("rep_row", exp_row, rep_row);
        u_ctl.issue(CMD_MRS, `PPR_MR4, 4'h0, '0);
        #1;
        chk("soft_mode", 0, soft_mode);
        chk("normal_cmd", 1, normal_cmd);
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        results;
    end

    initial begin
        resetn_i = 1'b0;
        ce_i = 1'b1;
        spare_ok = '1;
        exp_valid = '0;
        exp_row = '0;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        #1;
        chk("normal_cmd", 1, normal_cmd);
        chk("modes", 0, {soft_mode, hard_mode, dq_high, repair_done, rep_valid});
        u_ctl.issue(CMD_MRS, `PPR_MR4, 4'h0, ROW_W'(1) << `PPR_HARD_BIT);
        #1;
        chk("hard_mode", 1, {soft_mode, hard_mode});
        repeat (20) @(posedge mclk_i);
        u_ctl.issue(CMD_MRS, `PPR_MR4, 4'h0, '0);
        #1;
        chk("hard_mode", 0, hard_mode);
        repeat (5) @(posedge mclk_i);
        // a mode write with clock enable low must be ignored
        @(posedge mclk_i);
        ce_i <= 1'b0;
        u_ctl.issue(CMD_MRS, `PPR_MR4, 4'h0, ROW_W'(1) << `PPR_SOFT_BIT);
        ce_i <= 1'b1;
        #1;
        chk("ce_freeze", 0, {soft_mode, ~normal_cmd});
        seq(4'h3, 18'h2a5a5, '0, 0);
        seq(4'h3, 18'h01234, '0, 0);
        seq(4'h5, 18'h3ffff, '0, 1);
        seq(4'h5, 18'h00001, '0, 2);
        seq(4'h6, 18'h00010, 16'h0010, 0);
        seq(4'h6, 18'h00020, 16'hffff, 0);
        @(posedge mclk_i);
        spare_ok <= 16'hff7f;
        seq(4'h7, 18'h15555, '0, 0);
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk_i);
            spare_ok <= 16'($random(seed));
            seq(4'($random(seed)), ROW_W'($random(seed)), ($random(seed) & 1) ? 16'h0 : 16'($random(seed)), 0);
        end
        // a reset in mid-run forgets every repair
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        exp_valid = '0;
        exp_row = '0;
        #1;
        chk("rep_valid", exp_valid, rep_valid);
        chk("rep_row", exp_row, rep_row);
        results;
    end
endmodule
